//--- verilog/vai_consts.svh
// Constants of the blanking-interval ancillary data inserter.
// Assumes inclusion by bare name.
`ifndef VAI_CONSTS_SVH
`define VAI_CONSTS_SVH

// ----------------------------------------------------------------
// Register subaddresses
// ----------------------------------------------------------------
`define VAI_ADDR_EVEN_CAP0    5'h0e
`define VAI_ADDR_EVEN_CAP1    5'h0f
`define VAI_ADDR_ODD_CAP0     5'h10
`define VAI_ADDR_ODD_CAP1     5'h11
`define VAI_ADDR_COPY_CTRL    5'h16
`define VAI_ADDR_COPY_MID     5'h17
`define VAI_ADDR_COPY_LOW     5'h18
`define VAI_ADDR_STATUS       5'h1f

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define VAI_BIT_AUTO_CHECK    3'd4
`define VAI_BIT_COPY_ODD_EN   3'd5
`define VAI_BIT_COPY_EVEN_EN  3'd6
`define VAI_BIT_WIDE_EN       3'd7
`define VAI_REG_RESET         8'h00
`define VAI_CHECK_PRESET      6'h3f
`define VAI_CHECK_POLY        6'h03

// ----------------------------------------------------------------
// Line numbers (frame line count)
// ----------------------------------------------------------------
`define VAI_LINE_CAP_ODD      10'h015
`define VAI_LINE_CAP_EVEN     10'h11c
`define VAI_LINE_COPY_ODD     10'h014
`define VAI_LINE_COPY_EVEN    10'h11b
`define VAI_LINE_WIDE         10'h017

// ----------------------------------------------------------------
// Waveform timing in output samples, and levels
// ----------------------------------------------------------------
`define VAI_CAP_START         11'h0f0
`define VAI_COPY_START        11'h0f0
`define VAI_WIDE_START        11'h0b0
`define VAI_CAP_BIT_LEN       8'h1a
`define VAI_COPY_BIT_LEN      8'h1c
`define VAI_WIDE_BIT_LEN      8'h0b
`define VAI_RUNIN_CYCLES      5'h07
`define VAI_CAP_BITS          5'h13
`define VAI_COPY_BITS         5'h15
`define VAI_WIDE_BITS         5'h0e
`define VAI_LVL_BLANK         8'h10
`define VAI_LVL_HIGH          8'h7e

`endif

//--- verilog/vai_pkg.sv
// Types shared by the blanking-interval ancillary data inserter.
// Assumes nothing of its surroundings.
package vai_pkg;

    // Serializer sequencing
    typedef enum logic [1:0] {VAI_IDLE, VAI_RUNIN, VAI_BITS} vai_state_t;

endpackage : vai_pkg

//--- verilog/vai_fifo.sv
// Sample FIFO with registered head, valid and ready.
// Assumes one clock; shift-down storage keeps the head in slot 0.
`timescale 1ns/1ps
`default_nettype none

module vai_fifo
    import vai_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [CW-1:0]    count_reg;
    logic [CW-1:0]    count_next;
    wire              push = in_valid_i && in_ready_o;
    wire              pop  = out_valid_o && out_ready_i;

    // ----------------------------------------------------------------
    // Occupancy
    // ----------------------------------------------------------------
    assign count_next = count_reg + CW'(push) - CW'(pop);

    // Registered flags keep the ports on flops
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            count_reg   <= '0;
            out_valid_o <= 1'b0;
            in_ready_o  <= 1'b1;
        end
        else
        begin
            count_reg   <= count_next;
            out_valid_o <= (count_next != '0);
            in_ready_o  <= (count_next != CW'(DEPTH));
        end
    end

    // ----------------------------------------------------------------
    // Storage: each slot takes its upper neighbour on a pop
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < DEPTH; g++)
        begin : g_slot
            wire [CW-1:0]    wr_slot = pop ? count_reg - CW'(1) : count_reg;
            wire [WIDTH-1:0] upper   = (g == DEPTH - 1) ? '0 : mem_reg[(g + 1) % DEPTH];
            wire [WIDTH-1:0] slot_next =
                (push && wr_slot == CW'(g)) ? in_data_i : (pop ? upper : mem_reg[g]);
            always_ff @(posedge clk_i)
            begin
                if (rst_i)
                    mem_reg[g] <= '0;
                else
                    mem_reg[g] <= slot_next;
            end
        end
    endgenerate

    assign out_data_o = mem_reg[0];

endmodule : vai_fifo

`default_nettype wire

//--- verilog/vai_inserter.sv
// Blanking-interval ancillary data inserter: caption, copy-management and
// wide-screen signalling waveforms spliced into the luma sample stream.
// Assumes the timing generator, register port and pixel source share clk_i.
`timescale 1ns/1ps
`default_nettype none
`include "vai_consts.svh"

module vai_inserter
    import vai_pkg::*;
#(
    parameter int FIFO_DEPTH = 8,
    parameter int LINE_W     = 10
)
(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic [4:0]        reg_addr_i,
    input  wire logic [7:0]        reg_wdata_i,
    input  wire logic              reg_we_i,
    output logic      [7:0]        reg_rdata_o,
    input  wire logic              pal_mode_i,
    input  wire logic [LINE_W-1:0] line_i,
    input  wire logic              pix_valid_i,
    input  wire logic [7:0]        pix_data_i,
    output logic                   pix_ready_o,
    output logic                   out_valid_o,
    output logic      [7:0]        out_data_o,
    input  wire logic              out_ready_i
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Seven data bits with odd parity appended as bit 7
    function automatic logic [7:0] cap_byte(input logic [7:0] r);
        cap_byte = {~^r[6:0], r[6:0]};
    endfunction : cap_byte

    // Check sequence over payload bits 0-13, first bit in first
    function automatic logic [5:0] check_bits(input logic [13:0] c);
        logic [5:0] crc;
        logic       fb;
        crc = `VAI_CHECK_PRESET;
        fb  = 1'b0;
        for (int i = 0; i < 14; i++)
        begin
            fb  = c[i] ^ crc[5];
            crc = {crc[4:0], 1'b0} ^ ({6{fb}} & `VAI_CHECK_POLY);
        end
        check_bits = crc;
    endfunction : check_bits

    // Sixteen-point sine with its trough at blanking, one run-in cycle per sweep
    function automatic logic [7:0] sine_lvl(input logic [3:0] ph);
        case (ph)
            4'h0, 4'h8: sine_lvl = 8'h47;
            4'h1, 4'h7: sine_lvl = 8'h5f;
            4'h2, 4'h6: sine_lvl = 8'h74;
            4'h3, 4'h5: sine_lvl = 8'h80;
            4'h4:       sine_lvl = 8'h84;
            4'h9, 4'hf: sine_lvl = 8'h2f;
            4'ha, 4'he: sine_lvl = 8'h1a;
            4'hb, 4'hd: sine_lvl = 8'h0e;
            default:    sine_lvl = `VAI_LVL_BLANK;
        endcase
    endfunction : sine_lvl

    // ----------------------------------------------------------------
    // Registers written over the subaddress port
    // ----------------------------------------------------------------
    logic [7:0] even_cap0_reg;
    logic [7:0] even_cap1_reg;
    logic [7:0] odd_cap0_reg;
    logic [7:0] odd_cap1_reg;
    logic [7:0] copy_ctrl_reg;
    logic [7:0] copy_wide_payload_mid_reg;
    logic [7:0] copy_wide_payload_low_reg;

    // Plain storage; sampled only at sequence start
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            even_cap0_reg             <= `VAI_REG_RESET;
            even_cap1_reg             <= `VAI_REG_RESET;
            odd_cap0_reg              <= `VAI_REG_RESET;
            odd_cap1_reg              <= `VAI_REG_RESET;
            copy_ctrl_reg             <= `VAI_REG_RESET;
            copy_wide_payload_mid_reg <= `VAI_REG_RESET;
            copy_wide_payload_low_reg <= `VAI_REG_RESET;
        end
        else if (reg_we_i)
        begin
            case (reg_addr_i)
                `VAI_ADDR_EVEN_CAP0: even_cap0_reg             <= reg_wdata_i;
                `VAI_ADDR_EVEN_CAP1: even_cap1_reg             <= reg_wdata_i;
                `VAI_ADDR_ODD_CAP0:  odd_cap0_reg              <= reg_wdata_i;
                `VAI_ADDR_ODD_CAP1:  odd_cap1_reg              <= reg_wdata_i;
                `VAI_ADDR_COPY_CTRL: copy_ctrl_reg             <= reg_wdata_i;
                `VAI_ADDR_COPY_MID:  copy_wide_payload_mid_reg <= reg_wdata_i;
                `VAI_ADDR_COPY_LOW:  copy_wide_payload_low_reg <= reg_wdata_i;
                default:             ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Line tracking and sequence triggers
    // ----------------------------------------------------------------
    vai_state_t        state_reg;
    logic [LINE_W-1:0] line_prev_reg;
    logic [10:0]       pos_reg;
    wire               fifo_ready;
    wire               accept   = pix_valid_i && fifo_ready;
    wire               new_line = (line_i != line_prev_reg);
    wire [10:0]        pos_now  = new_line ? 11'h000 : pos_reg;
    wire               idle     = (state_reg == VAI_IDLE);

    // Caption lines belong to the inserter end to end
    wire cap_odd_line  = !pal_mode_i && line_i == `VAI_LINE_CAP_ODD;
    wire cap_even_line = !pal_mode_i && line_i == `VAI_LINE_CAP_EVEN;
    wire cap_line      = cap_odd_line || cap_even_line;

    wire copy_odd  = !pal_mode_i && line_i == `VAI_LINE_COPY_ODD
                     && copy_ctrl_reg[`VAI_BIT_COPY_ODD_EN];
    wire copy_even = !pal_mode_i && line_i == `VAI_LINE_COPY_EVEN
                     && copy_ctrl_reg[`VAI_BIT_COPY_EVEN_EN];
    wire wide_go   = pal_mode_i && line_i == `VAI_LINE_WIDE
                     && copy_ctrl_reg[`VAI_BIT_WIDE_EN];

    wire start_cap  = accept && idle && cap_line && pos_now == `VAI_CAP_START;
    wire start_copy = accept && idle && (copy_odd || copy_even)
                      && pos_now == `VAI_COPY_START;
    wire start_wide = accept && idle && wide_go && pos_now == `VAI_WIDE_START;

    // ----------------------------------------------------------------
    // Payload assembly, first bit sent in bit 0
    // ----------------------------------------------------------------
    wire [7:0] cap_lo = cap_odd_line ? cap_byte(odd_cap0_reg)
                                     : cap_byte(even_cap0_reg);
    wire [7:0] cap_hi = cap_odd_line ? cap_byte(odd_cap1_reg)
                                     : cap_byte(even_cap1_reg);
    // Two blank bits, start bit, then each byte LSB first
    wire [20:0] cap_vec = {2'b00, cap_hi, cap_lo, 1'b1, 2'b00};

    wire [13:0] copy_c13_0 = {copy_wide_payload_mid_reg[5:0],
                              copy_wide_payload_low_reg};
    wire [5:0]  copy_calc  = check_bits(copy_c13_0);
    wire [5:0]  copy_store = {copy_ctrl_reg[3:0],
                              copy_wide_payload_mid_reg[7:6]};
    wire [5:0]  copy_c19_14 = copy_ctrl_reg[`VAI_BIT_AUTO_CHECK]
                              ? copy_calc : copy_store;
    // Reference pulse leads the twenty payload bits
    wire [20:0] copy_vec = {copy_c19_14, copy_c13_0, 1'b1};

    // Wide word never sees mid bits 6-7
    wire [20:0] wide_vec = {7'h00, copy_wide_payload_mid_reg[5:0],
                            copy_wide_payload_low_reg};

    // ----------------------------------------------------------------
    // Serializer
    // ----------------------------------------------------------------
    logic [20:0] shift_reg;
    logic [7:0]  bit_len_reg;
    logic [7:0]  samp_reg;
    logic [4:0]  bits_left_reg;
    logic [4:0]  runin_bit_reg;
    logic        on_cap_reg;

    wire        bit_end   = (samp_reg == bit_len_reg - 8'h01);
    wire [4:0]  runin_len = `VAI_RUNIN_CYCLES << 1;
    // Run-in phase over two bit periods, in 16 steps
    wire [15:0] runin_pos = {8'h00, samp_reg} +
                            (runin_bit_reg[0] ? {8'h00, bit_len_reg} : 16'h0000);
    wire [19:0] ph_scaled = {runin_pos, 4'h0} / {11'h000, bit_len_reg, 1'b0};
    wire [3:0]  ph        = ph_scaled[3:0];

    // Sample chosen for the slot now being accepted
    wire [7:0] gen_sample =
        (state_reg == VAI_RUNIN) ? sine_lvl(ph) :
        (state_reg == VAI_BITS)  ? (shift_reg[0] ? `VAI_LVL_HIGH
                                                 : `VAI_LVL_BLANK) :
        cap_line                 ? `VAI_LVL_BLANK : pix_data_i;

    // Advances only on accepted samples: a stalled sink stretches, never corrupts
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            state_reg     <= VAI_IDLE;
            line_prev_reg <= '0;
            pos_reg       <= 11'h000;
            shift_reg     <= 21'h000000;
            bit_len_reg   <= `VAI_CAP_BIT_LEN;
            samp_reg      <= 8'h00;
            bits_left_reg <= 5'h00;
            runin_bit_reg <= 5'h00;
            on_cap_reg    <= 1'b0;
        end
        else if (accept)
        begin
            line_prev_reg <= line_i;
            pos_reg       <= pos_now + 11'h001;
            case (state_reg)
                VAI_IDLE:
                begin
                    samp_reg      <= 8'h00;
                    runin_bit_reg <= 5'h00;
                    if (start_cap)
                    begin
                        // Bytes latch here; a write by the line before lands
                        shift_reg     <= cap_vec;
                        bit_len_reg   <= `VAI_CAP_BIT_LEN;
                        bits_left_reg <= `VAI_CAP_BITS;
                        on_cap_reg    <= 1'b1;
                        state_reg     <= VAI_RUNIN;
                    end
                    else if (start_copy)
                    begin
                        shift_reg     <= copy_vec;
                        bit_len_reg   <= `VAI_COPY_BIT_LEN;
                        bits_left_reg <= `VAI_COPY_BITS;
                        on_cap_reg    <= 1'b0;
                        state_reg     <= VAI_BITS;
                    end
                    else if (start_wide)
                    begin
                        shift_reg     <= wide_vec;
                        bit_len_reg   <= `VAI_WIDE_BIT_LEN;
                        bits_left_reg <= `VAI_WIDE_BITS;
                        on_cap_reg    <= 1'b0;
                        state_reg     <= VAI_BITS;
                    end
                end
                VAI_RUNIN:
                begin
                    samp_reg <= bit_end ? 8'h00 : samp_reg + 8'h01;
                    if (bit_end)
                    begin
                        runin_bit_reg <= runin_bit_reg + 5'h01;
                        if (runin_bit_reg == runin_len - 5'h01)
                            state_reg <= VAI_BITS;
                    end
                end
                VAI_BITS:
                begin
                    samp_reg <= bit_end ? 8'h00 : samp_reg + 8'h01;
                    if (bit_end)
                    begin
                        shift_reg     <= {1'b0, shift_reg[20:1]};
                        bits_left_reg <= bits_left_reg - 5'h01;
                        if (bits_left_reg == 5'h01)
                            state_reg <= VAI_IDLE;
                    end
                end
                default:
                    state_reg <= VAI_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Register read-back, one cycle after the address
    // ----------------------------------------------------------------
    wire [7:0] status_word = {4'h0, cap_line, on_cap_reg, state_reg};
    wire [7:0] rd_mux =
        (reg_addr_i == `VAI_ADDR_EVEN_CAP0) ? even_cap0_reg :
        (reg_addr_i == `VAI_ADDR_EVEN_CAP1) ? even_cap1_reg :
        (reg_addr_i == `VAI_ADDR_ODD_CAP0)  ? odd_cap0_reg  :
        (reg_addr_i == `VAI_ADDR_ODD_CAP1)  ? odd_cap1_reg  :
        (reg_addr_i == `VAI_ADDR_COPY_CTRL) ? copy_ctrl_reg :
        (reg_addr_i == `VAI_ADDR_COPY_MID)  ? copy_wide_payload_mid_reg :
        (reg_addr_i == `VAI_ADDR_COPY_LOW)  ? copy_wide_payload_low_reg :
        (reg_addr_i == `VAI_ADDR_STATUS)    ? status_word : 8'h00;

    // Unmapped subaddresses read as zero
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            reg_rdata_o <= 8'h00;
        else
            reg_rdata_o <= rd_mux;
    end

    // ----------------------------------------------------------------
    // Output buffer; its ready throttles the pixel source
    // ----------------------------------------------------------------
    vai_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) vai_fifo_i (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (pix_valid_i),
        .in_data_i   (gen_sample),
        .in_ready_o  (fifo_ready),
        .out_valid_o (out_valid_o),
        .out_data_o  (out_data_o),
        .out_ready_i (out_ready_i)
    );

    assign pix_ready_o = fifo_ready;

endmodule : vai_inserter

`default_nettype wire

//--- verification/vai_inserter_monitor.sv
// Port checker for the ancillary data inserter.
// Assumes a bind into vai_inserter; sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module vai_inserter_monitor
    import vai_pkg::*;
#(
    parameter int LINE_W = 10
)
(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic [4:0]        reg_addr_i,
    input wire logic [7:0]        reg_wdata_i,
    input wire logic              reg_we_i,
    input wire logic [7:0]        reg_rdata_o,
    input wire logic              pal_mode_i,
    input wire logic [LINE_W-1:0] line_i,
    input wire logic              pix_valid_i,
    input wire logic [7:0]        pix_data_i,
    input wire logic              pix_ready_o,
    input wire logic              out_valid_o,
    input wire logic [7:0]        out_data_o,
    input wire logic              out_ready_i
);
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Write then read of one place returns the byte
    property p_back(logic [4:0] a);
        (reg_we_i && reg_addr_i == a) ##1 (!reg_we_i && reg_addr_i == a)
            |=> reg_rdata_o == $past(reg_wdata_i, 2);
    endproperty

    AST_BACK_MID: assert property (p_back(5'h17))
        else $error("mid readback");
    AST_BACK_LOW: assert property (p_back(5'h18))
        else $error("low readback");
    AST_BACK_ODD0: assert property (p_back(5'h10))
        else $error("odd0 readback");
    AST_BACK_ODD1: assert property (p_back(5'h11))
        else $error("odd1 readback");
    AST_BACK_EVEN0: assert property (p_back(5'h0e))
        else $error("even0 readback");
    AST_BACK_CTRL: assert property (p_back(5'h16))
        else $error("ctrl readback");
    // A stalled sample must not move or vanish
    AST_HOLD: assert property (out_valid_o && !out_ready_i
        |=> out_valid_o && $stable(out_data_o)) else $error("stalled sample moved");
    // No extra latency when empty
    AST_FIRST: assert property (pix_valid_i && pix_ready_o && !out_valid_o
        |=> out_valid_o) else $error("late first sample");
    AST_ROOM: assert property (!pix_ready_o && out_valid_o && out_ready_i
        |=> pix_ready_o) else $error("no room after drain");

    cover property (!pix_ready_o);
    cover property (reg_we_i && reg_addr_i == 5'h10);
    cover property (pal_mode_i && line_i == 10'h017 && out_valid_o);
endmodule : vai_inserter_monitor

`default_nettype wire

//--- verification/vai_tv_rx.sv
// Receiver model taking the inserter's samples.
// Assumes the bench clears the got queue per line.
`timescale 1ns/1ps
`default_nettype none

module vai_tv_rx
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       valid_i,
    input  wire logic [7:0] data_i,
    input  wire logic [1:0] mode_i,
    output logic            ready_o
);
    // ----------------------------------------------------------------
    // Pacing and capture
    // ----------------------------------------------------------------
    logic [1:0] slot_reg;
    logic [7:0] got[$];

    // 0 always ready, 1 stalls 1 in 4, 2 stalls all
    assign ready_o = (mode_i == 2'd0) || (mode_i == 2'd1 && slot_reg != 2'd0);

    // Keeps taken samples in order
    always @(posedge clk_i)
    begin
        slot_reg <= rst_i ? 2'd0 : slot_reg + 2'd1;
        if (!rst_i && valid_i && ready_o)
            got.push_back(data_i);
    end
endmodule : vai_tv_rx

`default_nettype wire

//--- verification/vai_inserter_bench.sv
// Self-checking bench for the ancillary data inserter.
// Assumes the design, receiver and monitor are compiled.
`timescale 1ns/1ps
`default_nettype none

module vai_inserter_bench;
    import vai_pkg::*;
    logic clk_i, rst_i, reg_we_i, pal_mode_i, pix_valid_i, pix_ready_o;
    logic out_valid_o, out_ready_i;
    logic [4:0] reg_addr_i;
    logic [7:0] reg_wdata_i, reg_rdata_o, pix_data_i, out_data_o;
    logic [9:0] line_i;
    logic [1:0] rx_mode;
    int errors, num_checks;

    vai_inserter vai_inserter_i (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_rdata_o(reg_rdata_o),
        .pal_mode_i(pal_mode_i), .line_i(line_i), .pix_valid_i(pix_valid_i),
        .pix_data_i(pix_data_i), .pix_ready_o(pix_ready_o), .out_valid_o(out_valid_o),
        .out_data_o(out_data_o), .out_ready_i(out_ready_i));
    vai_tv_rx rx_i (.clk_i(clk_i), .rst_i(rst_i), .valid_i(out_valid_o),
        .data_i(out_data_o), .mode_i(rx_mode), .ready_o(out_ready_i));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string nm, input logic [15:0] exp, act);
        num_checks++;
        if (act !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, act);
        end
    endtask : chk

    // One access, then a readback
    task automatic reg_acc(input logic [4:0] a, input logic [7:0] d, input logic we,
                           input logic [7:0] exp);
        @(posedge clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_we_i    <= we;
        @(posedge clk_i);
        reg_we_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        chk("register", exp, reg_rdata_o);
    endtask : reg_acc

    // Offers pixels numbered from zero
    task automatic push(input int n, input int lim, output int k);
        logic acc;
        k = 0;
        pix_data_i  <= 8'h00;
        pix_valid_i <= 1'b1;
        for (int t = 0; t < lim && k < n; t++)
        begin
            @(negedge clk_i);
            acc = pix_ready_o;
            @(posedge clk_i);
            if (acc)
            begin
                k++;
                pix_data_i <= 8'(k);
            end
        end
        pix_valid_i <= 1'b0;
    endtask : push

    task automatic run_line(input logic [9:0] ln, input int n);
        int k;
        rx_i.got.delete();
        @(posedge clk_i);
        line_i <= ln;
        push(n, 4 * n, k);
        for (int t = 0; t < 300 && rx_i.got.size() < n; t++)
            @(posedge clk_i);
        chk("sample count", 16'(n), 16'(rx_i.got.size()));
    endtask : run_line

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic test_regs();
        reg_acc(5'h17, 8'h00, 1'b0, 8'h00);
        reg_acc(5'h18, 8'h00, 1'b0, 8'h00);
        reg_acc(5'h05, 8'ha5, 1'b1, 8'h00);
        $display("registers done");
    endtask : test_regs

    // Sink refuses all; the buffer stops at its depth
    task automatic test_fill();
        int k;
        rx_i.got.delete();
        rx_mode <= 2'd2;
        @(posedge clk_i);
        line_i <= 10'd22;
        push(30, 30, k);
        chk("fill depth", 8'd8, 8'(k));
        rx_mode <= 2'd1;
        for (int t = 0; t < 100 && rx_i.got.size() < 8; t++)
            @(posedge clk_i);
        for (int j = 0; j < 8; j++)
            chk("pass order", 8'(j), rx_i.got[j]);
        $display("fill done");
    endtask : test_fill

    task automatic test_caption(input logic [9:0] ln, input logic [4:0] a,
                                input logic [7:0] b0, b1);
        logic [18:0] bits;
        reg_acc(a, b0, 1'b1, b0);
        reg_acc(a + 5'h01, b1, 1'b1, b1);
        bits = {~^b1[6:0], b1[6:0], ~^b0[6:0], b0[6:0], 3'b100};
        run_line(ln, 1110);
        reg_acc(5'h1f, 8'h00, 1'b0, 8'h0c);
        for (int j = 0; j < 240; j += 7)
            chk("caption lead", 8'h10, rx_i.got[j]);
        chk("run-in period", rx_i.got[250], rx_i.got[302]);
        chk("run-in swing", 8'h01, 16'(rx_i.got[250] != rx_i.got[276]));
        for (int k = 0; k < 19; k++)
            chk("caption bit", bits[k] ? 8'h7e : 8'h10, rx_i.got[617 + k * 26]);
        $display("caption line %0d done", ln);
    endtask : test_caption

    task automatic test_copy();
        logic [19:0] c;
        logic [5:0]  crc;
        reg_acc(5'h18, 8'h3c, 1'b1, 8'h3c);
        reg_acc(5'h17, 8'h96, 1'b1, 8'h96);
        for (int au = 0; au < 2; au++)
        begin
            reg_acc(5'h16, au ? 8'h3a : 8'h2a, 1'b1, au ? 8'h3a : 8'h2a);
            c = {4'ha, 8'h96, 8'h3c};
            crc = 6'h3f;
            for (int i = 0; i < 14; i++)
                crc = {crc[4:0], 1'b0} ^ ((c[i] ^ crc[5]) ? 6'h03 : 6'h00);
            if (au)
                c[19:14] = crc;
            run_line(10'd20, 840);
            chk("copy reference", 8'h7e, rx_i.got[254]);
            for (int k = 0; k < 20; k++)
                chk("copy bit", c[k] ? 8'h7e : 8'h10, rx_i.got[282 + k * 28]);
            run_line(10'd283, 300);
            chk("even copy off", 8'd254, rx_i.got[254]);
        end
        $display("copy done");
    endtask : test_copy

    task automatic test_wide();
        logic [13:0] w;
        pal_mode_i <= 1'b1;
        reg_acc(5'h16, 8'h80, 1'b1, 8'h80);
        w = {6'h16, 8'h3c};
        run_line(10'd23, 340);
        for (int k = 0; k < 14; k++)
            chk("wide bit", w[k] ? 8'h7e : 8'h10, rx_i.got[181 + k * 11]);
        run_line(10'd20, 300);
        chk("pal copy off", 8'd254, rx_i.got[254]);
        $display("wide done");
    endtask : test_wide

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : summarize

    // ----------------------------------------------------------------
    // Clock, watchdog and sequence
    // ----------------------------------------------------------------
    initial
    begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    // About 10k cycles expected; 50k means a hang
    initial
    begin
        #500000;
        errors++;
        summarize();
    end

    initial
    begin
        {rst_i, reg_we_i, pal_mode_i, pix_valid_i} = 4'b1000;
        {reg_addr_i, reg_wdata_i, pix_data_i, line_i, rx_mode} = '0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        test_regs();
        test_fill();
        test_caption(10'd21, 5'h10, 8'h41, 8'h07);
        test_caption(10'd284, 5'h0e, 8'h52, 8'h7f);
        test_caption(10'd21, 5'h10, 8'h00, 8'h00);
        test_copy();
        test_wide();
        summarize();
    end
endmodule : vai_inserter_bench

bind vai_inserter vai_inserter_monitor #(.LINE_W(LINE_W)) vai_inserter_monitor_i (
    .clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i), .reg_rdata_o(reg_rdata_o), .pal_mode_i(pal_mode_i),
    .line_i(line_i), .pix_valid_i(pix_valid_i), .pix_data_i(pix_data_i),
    .pix_ready_o(pix_ready_o), .out_valid_o(out_valid_o), .out_data_o(out_data_o),
    .out_ready_i(out_ready_i));

`default_nettype wire
